/* verilog/eeseq_consts.vh */
// eeseq_consts.vh: constants of the serial eeprom access sequencer
// assumes: included by the sequencer, its checker and the bench; the array memory does not use it
`ifndef EESEQ_CONSTS_VH
`define EESEQ_CONSTS_VH

`define EESEQ_DEV_CODE    4'hA
`define EESEQ_PAGE_BITS   5
`define EESEQ_PAGE_BYTES  32
`define EESEQ_ADDR_BITS   13
// programming time in microseconds and its count at 250 MHz
`define EESEQ_TWR_US      10000
`define EESEQ_CLK_MHZ     250
`define EESEQ_TWR_CYC     (`EESEQ_TWR_US * `EESEQ_CLK_MHZ)
`define EESEQ_ADDR_RST    13'h0000

`endif

/* verilog/eeseq_mem.v */
// eeseq_mem.v: byte array of the eeprom, one write and one registered read port
// assumes: single clock, no reset of contents
`timescale 1ns/1ps
module eeseq_mem #(
    parameter AW = 13
) (
    input  wire          mclk_i,  // clock
    input  wire          we_i,    // write strobe
    input  wire [AW-1:0] waddr_i, // write address
    input  wire [7:0]    wdata_i, // write data
    input  wire [AW-1:0] raddr_i, // read address
    output reg  [7:0]    rdata_o  // registered read data
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* verilog/eeseq_top.v */
// eeseq_top.v: two-wire slave sequencer of a serial eeprom with 32-byte page buffer
// assumes: scl and sda come from the bus asynchronously; sda is open drain
`timescale 1ns/1ps
`include "eeseq_consts.vh"
module eeseq_top #(
    parameter AW      = `EESEQ_ADDR_BITS,  // 12 for the 32k part, 13 for 64k
    parameter TWR_CYC = `EESEQ_TWR_CYC     // programming time in clock cycles
) (
    input  wire       mclk_i,        // 250 MHz clock
    input  wire       rst_b_i,       // async reset, active low
    input  wire       scl_i,         // bus clock pin
    input  wire       sda_i,         // bus data pin level
    input  wire [2:0] dev_sel_i,     // device_select_inputs
    output reg        sda_o,         // data out, always low when driving
    output reg        sda_oe_o,      // high while pulling data low
    output reg        busy_o         // programming cycle running
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_DEV  = 7'h02;
    localparam [6:0] S_AHI  = 7'h04;
    localparam [6:0] S_ALO  = 7'h08;
    localparam [6:0] S_WDAT = 7'h10;
    localparam [6:0] S_RDAT = 7'h20;
    localparam [6:0] S_RACK = 7'h40;

    localparam PB = `EESEQ_PAGE_BITS;

    // ------------------------------------------------------------
    // pin synchronisers and edge finding
    // ------------------------------------------------------------
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_d;
    reg       sda_d;
    reg [2:0] sel_s0;
    reg [2:0] sel_s1;

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            sel_s0   <= 3'h0;
            sel_s1   <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
            // select pins are static, but still cross in from outside
            sel_s0   <= dev_sel_i;
            sel_s1   <= sel_s0;
        end
    end

    wire scl      = scl_sync[1];
    wire sda      = sda_sync[1];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c  = scl & scl_d & sda_d & ~sda;
    wire stop_c   = scl & scl_d & ~sda_d & sda;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    reg [6:0]    state;
    reg [3:0]    bitcnt;         // 0..7 data bits, 8 = ack slot
    reg [7:0]    shreg;
    reg          ack_pend;       // drive ack in the ninth clock
    reg [AW-1:0] addr;           // address counter
    reg [7:0]    ahi;
    reg [7:0]    page [0:`EESEQ_PAGE_BYTES-1];
    reg [`EESEQ_PAGE_BYTES-1:0] pvalid;
    reg          wr_armed;       // at least one data byte acked
    reg [AW-1:0] pbase;          // page of the buffered bytes
    reg [31:0]   twr_cnt;
    reg [PB:0]   flush_idx;      // commits buffered bytes into the array
    reg          flushing;
    reg [7:0]    txbyte;

    // next address with full wrap; one hook for both read paths
    function [AW-1:0] inc_full;
        input [AW-1:0] a;
        begin
            inc_full = a + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    wire [7:0]    rx_byte = {shreg[6:0], sda};
    wire [15:0]   full_addr = {ahi, shreg};
    // judged on the completed byte, after the eighth rise
    wire          dev_hit = (shreg[7:4] == `EESEQ_DEV_CODE)
                            && (shreg[3:1] == sel_s1);
    wire [AW-1:0] page_inc = {addr[AW-1:PB], addr[PB-1:0] + {{(PB-1){1'b0}}, 1'b1}};

    // memory port: commit on flush, read at the address counter
    wire          mem_we    = flushing & pvalid[flush_idx[PB-1:0]];
    wire [AW-1:0] mem_waddr = {pbase[AW-1:PB], flush_idx[PB-1:0]};
    wire [7:0]    mem_rdata;

    eeseq_mem #(.AW(AW)) u_mem (
        .mclk_i  (mclk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (page[flush_idx[PB-1:0]]),
        .raddr_i (addr),
        .rdata_o (mem_rdata)
    );

    integer i;

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state     <= S_IDLE;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            ack_pend  <= 1'b0;
            addr      <= `EESEQ_ADDR_RST;
            ahi       <= 8'h00;
            pvalid    <= {`EESEQ_PAGE_BYTES{1'b0}};
            wr_armed  <= 1'b0;
            pbase     <= `EESEQ_ADDR_RST;
            twr_cnt   <= 32'h0;
            flush_idx <= {(PB+1){1'b0}};
            flushing  <= 1'b0;
            txbyte    <= 8'h00;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
            busy_o    <= 1'b0;
            for (i = 0; i < `EESEQ_PAGE_BYTES; i = i + 1) begin
                page[i] <= 8'h00;
            end
        end else if (busy_o) begin
            // bus is deaf while programming; pins released
            sda_oe_o <= 1'b0;
            state    <= S_IDLE;
            if (flushing) begin
                if (flush_idx == `EESEQ_PAGE_BYTES - 1) begin
                    flushing <= 1'b0;
                end
                flush_idx <= flush_idx + {{PB{1'b0}}, 1'b1};
            end
            if (twr_cnt == 32'h0) begin
                busy_o <= 1'b0;
                pvalid <= {`EESEQ_PAGE_BYTES{1'b0}};
            end else begin
                twr_cnt <= twr_cnt - 32'h1;
            end
        end else if (stop_c) begin
            sda_oe_o <= 1'b0;
            state    <= S_IDLE;
            wr_armed <= 1'b0;
            if (wr_armed) begin
                busy_o    <= 1'b1;
                flushing  <= 1'b1;
                flush_idx <= {(PB+1){1'b0}};
                twr_cnt   <= TWR_CYC - 1;
            end else begin
                pvalid <= {`EESEQ_PAGE_BYTES{1'b0}};
            end
        end else if (start_c) begin
            // repeated start abandons any pending page write
            sda_oe_o <= 1'b0;
            state    <= S_DEV;
            bitcnt   <= 4'h0;
            ack_pend <= 1'b0;
            wr_armed <= 1'b0;
            pvalid   <= {`EESEQ_PAGE_BYTES{1'b0}};
        end else if (scl_rise && state != S_IDLE && bitcnt < 4'h8) begin
            shreg  <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
        end else if (scl_rise && bitcnt == 4'h8 && state == S_RDAT) begin
            // master's ack bit sampled in the ninth clock
            state <= sda ? S_IDLE : S_RACK;
        end else if (scl_fall) begin
            if (bitcnt == 4'h8 && !ack_pend) begin
                // byte complete: decide and drive ack
                ack_pend <= 1'b1;
                case (state)
                    S_DEV: begin
                        if (dev_hit) begin
                            sda_oe_o <= 1'b1;
                            // read: first byte goes out at the ninth fall
                            state    <= shreg[0] ? S_RACK : S_AHI;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                    S_AHI: begin
                        ahi      <= shreg;
                        sda_oe_o <= 1'b1;
                        state    <= S_ALO;
                    end
                    S_ALO: begin
                        addr     <= full_addr[AW-1:0];
                        pbase    <= full_addr[AW-1:0];
                        sda_oe_o <= 1'b1;
                        state    <= S_WDAT;
                    end
                    S_WDAT: begin
                        page[addr[PB-1:0]]   <= shreg;
                        pvalid[addr[PB-1:0]] <= 1'b1;
                        addr     <= page_inc;
                        wr_armed <= 1'b1;
                        sda_oe_o <= 1'b1;
                    end
                    S_RDAT: begin
                        // master owns the ninth clock of a read byte
                        sda_oe_o <= 1'b0;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end else if (bitcnt == 4'h8) begin
                // end of ninth clock: release line, begin next byte
                ack_pend <= 1'b0;
                bitcnt   <= 4'h0;
                sda_oe_o <= 1'b0;
                if (state == S_RACK) begin
                    txbyte   <= mem_rdata;
                    sda_oe_o <= ~mem_rdata[7];
                    addr     <= inc_full(addr);
                    state    <= S_RDAT;
                end
            end else if (state == S_RDAT) begin
                // shift out the next data bit, msb first
                sda_oe_o <= ~txbyte[3'h7 - bitcnt[2:0]];
            end
        end
    end
endmodule

/* tb/eeseq_checker.sv */
// eeseq_checker.sv: pin-level assertions for the eeprom sequencer
// assumes: bound to eeseq_top; raw bus pins sampled on mclk_i
`timescale 1ns/1ps
`include "eeseq_consts.vh"
module eeseq_checker #(
    parameter AW      = 13,
    parameter TWR_CYC = 200
) (
    input wire       mclk_i,    // clock
    input wire       rst_b_i,   // async reset, active low
    input wire       scl_i,     // bus clock pin
    input wire       sda_i,     // bus data level
    input wire [2:0] dev_sel_i, // select pins
    input wire       sda_o,     // data out
    input wire       sda_oe_o,  // pull enable
    input wire       busy_o     // programming
);
    // ----------------------------------------
    // bus events seen on the raw pins
    // ----------------------------------------
    logic [31:0] bcnt;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [3:0]  since_stop;
    logic        scl_q;
    logic        sda_q;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bcnt <= '0;
            bits <= '0;
            sh <= '0;
            since_stop <= 4'hF;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (scl_i && !scl_q) sh <= {sh[6:0], sda_i};
            bcnt <= busy_o ? bcnt + 1 : '0;
            if (scl_i && scl_q && sda_q && !sda_i) bits <= '0;
            else if (scl_i && !scl_q && bits != 4'hF) bits <= bits + 4'h1;
            if (scl_i && scl_q && !sda_q && sda_i) since_stop <= '0;
            else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_busy_quiet; busy_o |-> !sda_oe_o; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while programming");
    property p_open_drain; sda_oe_o |-> !sda_o; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    property p_oe_hold; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data moved with clock high");
    property p_ack_stand; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
    a_ack_stand: assert property (p_ack_stand) else $error("low drive too short");
    property p_addr_quiet; bits < 4'h8 |-> !sda_oe_o; endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("drive inside address byte");
    property p_sel_match; bits == 4'h8 && sda_oe_o |-> sh[7:1] == {`EESEQ_DEV_CODE, dev_sel_i}; endproperty
    a_sel_match: assert property (p_sel_match) else $error("ack to a foreign address");
    property p_busy_stop; $rose(busy_o) |-> since_stop < 4'h8; endproperty
    a_busy_stop: assert property (p_busy_stop) else $error("busy without stop");
    property p_busy_min; $rose(busy_o) |=> busy_o [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy pulse short");
    property p_busy_len; $fell(busy_o) |-> bcnt == TWR_CYC; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule

bind eeseq_top eeseq_checker #(.AW(AW), .TWR_CYC(TWR_CYC)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .scl_i(scl_i), .sda_i(sda_i), .dev_sel_i(dev_sel_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));

/* tb/eeseq_master.sv */
// eeseq_master.sv: behavioural two-wire bus master, scl period 12 clocks
// assumes: sda_i is the wired level; the bench pulls the line up
`timescale 1ns/1ps
module eeseq_master (
    input  wire mclk_i,    // bench clock
    input  wire sda_i,     // wire level
    output reg  scl_o,     // bus clock
    output reg  sda_low_o  // pulls data low
);
    // ----------------------------------------
    // bus primitives
    // ----------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic start(); // also repeated start
        sda_low_o = 1'b0;
        tk(3);
        scl_o = 1'b1;
        tk(6);
        sda_low_o = 1'b1;
        tk(6);
        scl_o = 1'b0;
        tk(3);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        tk(3);
        scl_o = 1'b1;
        tk(6);
        sda_low_o = 1'b0;
        tk(6);
    endtask
    // data only moves mid-low, so it is stable while scl is high
    task automatic bitx(input logic b, output logic r);
        sda_low_o = !b;
        tk(3);
        scl_o = 1'b1;
        tk(3);
        r = sda_i;
        tk(3);
        scl_o = 1'b0;
        tk(3);
    endtask
    task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]); // msb first
        bitx(nak, a); // ninth clock
        ack = !a;
    endtask
endmodule

/* tb/test_serial_eeprom_access_sequencer.sv */
// test_serial_eeprom_access_sequencer.sv: directed bench of the sequencer
// assumes: eeseq_master drives the bus; programming time shortened
`timescale 1ns/1ps
`include "eeseq_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module test_serial_eeprom_access_sequencer;
    localparam logic [2:0] SEL = 3'h5;
    logic       mclk_i;
    logic       rst_b_i;
    logic       sda_o;
    logic       sda_oe_o;
    logic       busy_o;
    logic       scl;
    logic       m_low;
    logic [7:0] q;
    logic       ack;
    int         errors;
    int         num_checks;
    wire        sda = !(m_low || sda_oe_o); // pulled up line
    eeseq_top #(.AW(13), .TWR_CYC(200)) u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
        .dev_sel_i(SEL), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));
    eeseq_master u_m (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    // ----------------------------------------
    // shared steps and scenarios
    // ----------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d);
        u_m.xfer(d, 1'b1, q, ack);
        `CHK(ack, 1'b1)
    endtask
    task automatic rb(input logic [7:0] e, input logic more);
        u_m.xfer(8'hFF, !more, q, ack);
        `CHK(q, e)
    endtask
    task automatic head(input logic [15:0] a);
        u_m.start();
        wb({`EESEQ_DEV_CODE, SEL, 1'b0});
        wb(a[15:8]);
        wb(a[7:0]);
    endtask
    task automatic rd_head();
        u_m.start();
        wb({`EESEQ_DEV_CODE, SEL, 1'b1});
    endtask
    task automatic fin_write(); // polls until acked, bounded
        u_m.stop();
        `CHK(busy_o, 1'b1)
        for (int n = 0; n < 20; n++) begin
            u_m.start();
            u_m.xfer({`EESEQ_DEV_CODE, SEL, 1'b0}, 1'b1, q, ack);
            u_m.stop();
            if (n == 0) `CHK(ack, 1'b0)
            if (ack === 1'b1) break;
        end
        if (ack !== 1'b1) begin
            errors++;
            results();
        end
    endtask
    task automatic t_select();
        logic [7:0] bad [2] = '{{4'hB, SEL, 1'b0}, {`EESEQ_DEV_CODE, 3'h2, 1'b1}};
        foreach (bad[i]) begin
            u_m.start();
            u_m.xfer(bad[i], 1'b1, q, ack);
            u_m.stop();
            `CHK(ack, 1'b0)
        end
    endtask
    task automatic t_byte_wrap(); // top address wraps to zero
        head(16'h0000);
        wb(8'h5A);
        fin_write();
        head(16'hFFFF);
        wb(8'hC3);
        fin_write();
        // a page write leaves the counter inside the page, so read the top byte first
        head(16'h1FFF);
        rd_head();
        rb(8'hC3, 1'b0);
        u_m.stop();
        rd_head();
        rb(8'h5A, 1'b0);
        u_m.stop();
        head(16'h1FFF);
        rd_head();
        rb(8'hC3, 1'b1);
        rb(8'h5A, 1'b0);
        u_m.stop();
    endtask
    task automatic t_abort(); // address only, no data byte
        head(16'h0000);
        u_m.stop();
        `CHK(busy_o, 1'b0)
        `CHK(sda_o, 1'b0)
    endtask
    task automatic t_page(); // 34 bytes: last two overwrite the first two
        head(16'h021E);
        for (int i = 0; i < 34; i++) wb(8'(i * 7 + 3));
        fin_write();
        head(16'h0200);
        rd_head();
        for (int o = 0; o < 32; o++) rb(8'((((o - 30) & 31) + (o >= 30 ? 32 : 0)) * 7 + 3), o < 31);
        u_m.stop();
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    initial begin
        errors = 0;
        num_checks = 0;
        rst_b_i = 1'b0;
        repeat (5) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        u_m.tk(4);
        t_select();
        t_byte_wrap();
        t_abort();
        t_page();
        results();
    end
endmodule
